// [verilog/lfc_top.sv]
// Linefeed state and dc feed control with serial register port
//
// What this block does
// - Six-bit open-circuit voltage code, 1.5 V steps.
// - Three-bit current limit, 20 mA plus 3 mA.
// - Six-bit common-mode offset, resets to 3 V.
// - Decode three-bit selector into eight line states.
// - Line control register write sets operating state.
// - Open state removes all drive on both leads.
// - Block can enter open state by itself.
// - Alarm sets flag, interrupt; forced open if enabled.
// - Active states feed line, audio path off.
// - On-hook transmission states power audio path.
// - Tip open: tip drive off, ring fed.
// - Ring open: ring drive off, tip fed.
// - Ringing state drives ringing waveform onto leads.
// - Results refreshed together at 800 Hz.
// - Loop voltage as sign plus six-bit magnitude.
// - Ground start reports ring voltage as loop voltage.
// - Loop current is half the pair difference sum.
// - One lead open: loop current left unhalved.
// - Twelve contiguous readable measurement result registers.
`timescale 1ns/10ps
`default_nettype none
`include "lfc_defs.svh"
module lfc_top
  import lfc_pkg::*;
#(
  parameter int REFRESH_CYCLES = `LFC_REFRESH_CYC
)
(
  // Clock, reset, enable
  input  wire logic   MCLK,
  input  wire logic   RST,
  input  wire logic   CE,
  // Serial control port
  input  wire logic   SCLK,
  input  wire logic   CS_N,
  input  wire logic   SDI,
  output logic        SDO_O,
  output logic        SDO_OE,
  // Converter samples and power alarm
  input  wire lfc_sense_t SENSE,
  input  wire logic   PWR_ALARM,
  // Line driver control
  output lfc_drive_t  DRIVE,
  output lfc_state_t  LINE_STATE_SEL,
  output logic [2:0]  FEED_CURRENT_CAP_SEL,
  output logic [5:0]  OPEN_LOOP_VOLT_SEL,
  output logic [5:0]  HEADROOM_OFFSET_SEL,
  // Alarm interrupt
  output logic        INT_N
);

  localparam logic [3:0] PIN_IDLE = `LFC_PIN_IDLE;

  // Control registers
  lfc_state_t sel_ff;
  logic [2:0] cap_ff;
  logic [5:0] ocv_ff;
  logic [5:0] hro_ff;
  logic [1:0] acfg_ff;
  logic       alarm_ff;
  logic       int_n_ff;
  lfc_drive_t drv_ff;

  // Serial engine state
  logic [4:0] bit_cnt_ff;
  logic [7:0] sh_in_ff;
  logic [7:0] cmd_ff;
  logic [7:0] sdo_sh_ff;
  logic       sdo_oe_ff;

  // Pin synchroniser results
  wire logic [3:0] pin_in;
  wire logic [3:0] pin_st;
  wire logic [3:0] pin_rise;
  wire logic [3:0] pin_fall;

  // Next values
  lfc_state_t nxt_sel;
  lfc_drive_t nxt_drv;
  wire logic  nxt_alarm;

  // Serial and alarm strobes, alarm settings
  wire logic  sclk_rise;
  wire logic  sclk_fall;
  wire logic  sel_n;
  wire logic  sdi_st;
  wire logic  alarm_evt;
  wire logic  auto_open_on_alarm;
  wire logic  alarm_ie;

  // Register bus decode
  wire logic  wr_stb;
  wire logic [6:0] wr_addr;
  wire logic [7:0] wr_data;
  wire logic [6:0] rd_addr;
  wire logic [7:0] rd_data;
  wire logic  in_res;
  wire logic [3:0] res_idx;
  wire logic  wr_line;
  wire logic  wr_cap;
  wire logic  wr_ocv;
  wire logic  wr_hro;
  wire logic  wr_acfg;
  wire logic  wr_stat;

  // Result registers from the converter
  lfc_results_t results;

  // Pins from outside: three stages, change taken once 2nd and 3rd agree
  assign pin_in = {PWR_ALARM, SDI, CS_N, SCLK};

  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_sync
    logic [2:0] sh_ff;
    logic       st_ff;
    logic       prev_ff;
    // Shift chain, agreed level and the level one clock back
    always_ff @(posedge MCLK) begin
      if (RST) begin
        sh_ff   <= {3{PIN_IDLE[gi]}};
        st_ff   <= PIN_IDLE[gi];
        prev_ff <= PIN_IDLE[gi];
      end else if (CE) begin
        sh_ff   <= {sh_ff[1:0], pin_in[gi]};
        prev_ff <= st_ff;
        if (sh_ff[1] == sh_ff[2]) begin
          st_ff <= sh_ff[2];
        end
      end
    end
    // Agreed level, and edge pulses that last one clock
    assign pin_st[gi]   = st_ff;
    assign pin_rise[gi] = st_ff & ~prev_ff;
    assign pin_fall[gi] = ~st_ff & prev_ff;
  end

  // Serial strobes, valid only while selected, so that
  // clock edges between frames count for nothing
  assign sel_n     = pin_st[1];
  assign sdi_st    = pin_st[2];
  assign sclk_rise = pin_rise[0] & ~sel_n;
  assign sclk_fall = pin_fall[0] & ~sel_n;
  assign alarm_evt = pin_rise[3];

  // Write strobe on the sixteenth rising serial clock
  assign wr_stb  = sclk_rise & (bit_cnt_ff == `LFC_SPI_DATA_LAST)
                 & ~cmd_ff[`LFC_BIT_RD];
  assign wr_addr = cmd_ff[6:0];
  assign wr_data = {sh_in_ff[6:0], sdi_st};

  // Serial shift-in, command capture and bit count
  always_ff @(posedge MCLK) begin
    if (RST) begin
      bit_cnt_ff <= 5'h00;
      sh_in_ff   <= 8'h00;
      cmd_ff     <= 8'h00;
    end else if (CE) begin
      if (sel_n) begin
        bit_cnt_ff <= 5'h00;
      end else if (sclk_rise && bit_cnt_ff != `LFC_SPI_END) begin
        sh_in_ff   <= {sh_in_ff[6:0], sdi_st};
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
        if (bit_cnt_ff == `LFC_SPI_CMD_LAST) begin
          cmd_ff <= {sh_in_ff[6:0], sdi_st};
        end
      end
    end
  end

  // Serial read data, shifted out on falling serial clock
  always_ff @(posedge MCLK) begin
    if (RST) begin
      sdo_sh_ff <= 8'h00;
      sdo_oe_ff <= 1'b0;
    end else if (CE) begin
      if (sel_n) begin
        sdo_oe_ff <= 1'b0;
      end else if (sclk_fall) begin
        if (bit_cnt_ff == `LFC_SPI_RD_LOAD && cmd_ff[`LFC_BIT_RD]) begin
          sdo_sh_ff <= rd_data;
          sdo_oe_ff <= 1'b1;
        end else if (bit_cnt_ff > `LFC_SPI_RD_LOAD) begin
          sdo_sh_ff <= {sdo_sh_ff[6:0], 1'b0};
        end
      end
    end
  end

  assign SDO_O  = sdo_sh_ff[7];
  assign SDO_OE = sdo_oe_ff;

  // Write address decode
  assign wr_line = wr_stb & (wr_addr == `LFC_ADR_LINE_CTRL);
  assign wr_cap  = wr_stb & (wr_addr == `LFC_ADR_CUR_LIMIT);
  assign wr_ocv  = wr_stb & (wr_addr == `LFC_ADR_OC_VOLT);
  assign wr_hro  = wr_stb & (wr_addr == `LFC_ADR_CM_VOLT);
  assign wr_acfg = wr_stb & (wr_addr == `LFC_ADR_ALARM_CFG);
  assign wr_stat = wr_stb & (wr_addr == `LFC_ADR_ALARM_STAT);

  // Read mux; results form one contiguous block, unmapped reads zero
  assign rd_addr = cmd_ff[6:0];
  assign in_res  = (rd_addr >= `LFC_ADR_RES_FIRST)
                 & (rd_addr <= `LFC_ADR_RES_LAST);
  // Offset into the block; only used while in_res holds
  assign res_idx = 4'(rd_addr - `LFC_ADR_RES_FIRST);
  assign rd_data =
      (rd_addr == `LFC_ADR_LINE_CTRL)  ? {5'h00, sel_ff} :
      (rd_addr == `LFC_ADR_CUR_LIMIT)  ? {5'h00, cap_ff} :
      (rd_addr == `LFC_ADR_OC_VOLT)    ? {2'h0, ocv_ff} :
      (rd_addr == `LFC_ADR_CM_VOLT)    ? {2'h0, hro_ff} :
      (rd_addr == `LFC_ADR_ALARM_CFG)  ? {6'h00, acfg_ff} :
      (rd_addr == `LFC_ADR_ALARM_STAT) ? {7'h00, alarm_ff} :
      in_res                           ? results[res_idx] : 8'h00;

  // Alarm settings and sticky flag; a new event beats a clear
  // so that an alarm in the clearing cycle is never lost
  assign auto_open_on_alarm = acfg_ff[`LFC_BIT_AUTO_OPEN];
  assign alarm_ie           = acfg_ff[`LFC_BIT_ALARM_IE];
  assign nxt_alarm = alarm_evt
                   | (alarm_ff
                      & ~(wr_stat & wr_data[`LFC_BIT_ALARM_FLAG]));

  // State selector: alarm with auto-open forces open over any write
  always_comb begin
    nxt_sel = sel_ff;
    if (alarm_evt && auto_open_on_alarm) begin
      nxt_sel = LFC_OPEN;
    end else if (wr_line) begin
      nxt_sel = lfc_state_t'(wr_data[2:0]);
    end
  end

  // State selector and alarm flag
  always_ff @(posedge MCLK) begin
    if (RST) begin
      sel_ff   <= lfc_state_t'(`LFC_RST_STATE);
      alarm_ff <= 1'b0;
    end else if (CE) begin
      sel_ff   <= nxt_sel;
      alarm_ff <= nxt_alarm;
    end
  end

  // Feed and alarm settings, each loaded by its own write
  always_ff @(posedge MCLK) begin
    if (RST) begin
      cap_ff   <= `LFC_RST_CUR_LIMIT;
      ocv_ff   <= `LFC_RST_OC_VOLT;
      hro_ff   <= `LFC_RST_CM_VOLT;
      acfg_ff  <= `LFC_RST_ALARM_CFG;
    end else if (CE) begin
      if (wr_cap) begin
        cap_ff <= wr_data[2:0];
      end
      if (wr_ocv) begin
        ocv_ff <= wr_data[5:0];
      end
      if (wr_hro) begin
        hro_ff <= wr_data[5:0];
      end
      if (wr_acfg) begin
        acfg_ff <= wr_data[1:0];
      end
    end
  end

  // Line state decode into driver and audio enables
  always_comb begin
    nxt_drv = '0;
    unique case (sel_ff)
      LFC_OPEN: begin
        nxt_drv = '0;
      end
      LFC_FWD_ACT: begin
        nxt_drv.tip_drive  = 1'b1;
        nxt_drv.ring_drive = 1'b1;
      end
      LFC_FWD_OHT: begin
        nxt_drv.tip_drive  = 1'b1;
        nxt_drv.ring_drive = 1'b1;
        nxt_drv.audio_pwr  = 1'b1;
      end
      LFC_TIP_OPEN: begin
        nxt_drv.ring_drive = 1'b1;
      end
      LFC_RINGING: begin
        nxt_drv.tip_drive  = 1'b1;
        nxt_drv.ring_drive = 1'b1;
        nxt_drv.ring_gen   = 1'b1;
      end
      LFC_REV_ACT: begin
        nxt_drv.tip_drive  = 1'b1;
        nxt_drv.ring_drive = 1'b1;
        nxt_drv.reverse    = 1'b1;
      end
      LFC_REV_OHT: begin
        nxt_drv.tip_drive  = 1'b1;
        nxt_drv.ring_drive = 1'b1;
        nxt_drv.audio_pwr  = 1'b1;
        nxt_drv.reverse    = 1'b1;
      end
      LFC_RING_OPEN: begin
        nxt_drv.tip_drive  = 1'b1;
      end
    endcase
  end

  // Registered driver enables and interrupt
  always_ff @(posedge MCLK) begin
    if (RST) begin
      drv_ff   <= '0;
      int_n_ff <= 1'b1;
    end else if (CE) begin
      drv_ff   <= nxt_drv;
      int_n_ff <= ~(alarm_ff & alarm_ie);
    end
  end

  assign DRIVE                = drv_ff;
  assign LINE_STATE_SEL       = sel_ff;
  assign FEED_CURRENT_CAP_SEL = cap_ff;
  assign OPEN_LOOP_VOLT_SEL   = ocv_ff;
  assign HEADROOM_OFFSET_SEL  = hro_ff;
  assign INT_N                = int_n_ff;

  // Converter results
  lfc_meas #(
    .REFRESH_CYCLES (REFRESH_CYCLES)
  ) u_meas (
    .clk     (MCLK),
    .rst     (RST),
    .ce      (CE),
    .sense   (SENSE),
    .state   (sel_ff),
    .results (results)
  );

endmodule
`default_nettype wire

// [pkg/lfc_defs.svh]
// Register map, field positions, reset values and timing counts
`ifndef LFC_DEFS_SVH
`define LFC_DEFS_SVH

// Register addresses on the serial control port
`define LFC_ADR_LINE_CTRL  7'h40
`define LFC_ADR_CUR_LIMIT  7'h47
`define LFC_ADR_OC_VOLT    7'h48
`define LFC_ADR_CM_VOLT    7'h49
`define LFC_ADR_ALARM_CFG  7'h42
`define LFC_ADR_ALARM_STAT 7'h13
`define LFC_ADR_RES_FIRST  7'h4E
`define LFC_ADR_RES_LAST   7'h59

// Reset values (codes)
`define LFC_RST_STATE      3'h0
`define LFC_RST_CUR_LIMIT  3'h0
`define LFC_RST_OC_VOLT    6'h20
`define LFC_RST_CM_VOLT    6'h02
`define LFC_RST_ALARM_CFG  2'h0

// Setting scales: base and step per code
`define LFC_CUR_BASE_UA    20000
`define LFC_CUR_STEP_UA    3000
`define LFC_OCV_STEP_MV    1500

// Field positions
`define LFC_BIT_AUTO_OPEN  0
`define LFC_BIT_ALARM_IE   1
`define LFC_BIT_ALARM_FLAG 0
`define LFC_BIT_RD         7
`define LFC_BIT_SIGN       7

// Measurement scaling
`define LFC_MAG_MAX        6'h3F
`define LFC_RAW_COUNT      10

// Serial frame bit counts
`define LFC_SPI_CMD_LAST   5'h07
`define LFC_SPI_RD_LOAD    5'h08
`define LFC_SPI_DATA_LAST  5'h0F
`define LFC_SPI_END        5'h10

// Pin idle levels: alarm, data in, select, serial clock
`define LFC_PIN_IDLE       4'h2

// Timing: clock rate and converter refresh rate
`define LFC_CLK_HZ         50000000
`define LFC_REFRESH_HZ     800
`define LFC_REFRESH_CYC    (`LFC_CLK_HZ / `LFC_REFRESH_HZ)

`endif

// [pkg/lfc_pkg.sv]
// Types shared by the linefeed control block
`default_nettype none
package lfc_pkg;

  // Linefeed operating states, encoded as the selector codes
  typedef enum logic [2:0] {
    LFC_OPEN      = 3'h0,
    LFC_FWD_ACT   = 3'h1,
    LFC_FWD_OHT   = 3'h2,
    LFC_TIP_OPEN  = 3'h3,
    LFC_RINGING   = 3'h4,
    LFC_REV_ACT   = 3'h5,
    LFC_REV_OHT   = 3'h6,
    LFC_RING_OPEN = 3'h7
  } lfc_state_t;

  // Enables toward the line drivers and audio path
  typedef struct packed {
    logic tip_drive;
    logic ring_drive;
    logic audio_pwr;
    logic ring_gen;
    logic reverse;
  } lfc_drive_t;

  // Raw converter samples; iq[0] is transistor 1
  typedef struct packed {
    logic [5:0][7:0] iq;
    logic [7:0]      vbat2;
    logic [7:0]      vbat1;
    logic [7:0]      vring;
    logic [7:0]      vtip;
  } lfc_sense_t;

  // Twelve result registers, entry 0 is loop voltage
  typedef logic [11:0][7:0] lfc_results_t;

endpackage
`default_nettype wire

// [verilog/lfc_meas.sv]
// Converter refresh, result capture and loop value derivation
`timescale 1ns/10ps
`default_nettype none
`include "lfc_defs.svh"
module lfc_meas
  import lfc_pkg::*;
#(
  parameter int REFRESH_CYCLES = `LFC_REFRESH_CYC
)
(
  // Clock, reset, enable
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   ce,
  // Converter samples and present line state
  input  wire lfc_sense_t sense,
  input  wire lfc_state_t state,
  // Result registers
  output lfc_results_t results
);

  localparam logic [15:0] TICK_LAST = 16'(REFRESH_CYCLES - 1);

  logic [15:0] cnt_ff;
  logic [7:0]  lv_ff;
  logic [7:0]  li_ff;

  wire logic       tick;
  wire logic [8:0] v_diff;
  wire logic [8:0] v_abs;
  wire logic [9:0] i_sum;
  wire logic [9:0] i_abs;
  wire logic [6:0] v_mag;
  wire logic [7:0] i_mag;
  wire logic       gnd_start;
  wire logic       lead_open;
  wire logic [7:0] nxt_lv;
  wire logic [7:0] nxt_li;
  wire logic [9:0][7:0] raw;

  // Refresh strobe at the converter rate
  assign tick = (cnt_ff == TICK_LAST);

  // Loop voltage: ring minus tip, ring alone for ground start
  assign gnd_start = (state == LFC_TIP_OPEN);
  assign v_diff = {1'b0, sense.vring} - {1'b0, sense.vtip};
  assign v_abs  = v_diff[8] ? (~v_diff + 9'h001) : v_diff;
  assign v_mag  = gnd_start ? {1'b0, sense.vring[7:2]} : v_abs[8:2];
  assign nxt_lv = {gnd_start | v_diff[8], 1'b0,
                   (v_mag > 7'h3F) ? `LFC_MAG_MAX : v_mag[5:0]};

  // Loop current: halved pair sum, unhalved with one lead open
  assign lead_open = (state == LFC_TIP_OPEN) | (state == LFC_RING_OPEN);
  assign i_sum = {2'h0, sense.iq[0]} - {2'h0, sense.iq[1]}
               + {2'h0, sense.iq[4]} - {2'h0, sense.iq[5]};
  assign i_abs = i_sum[9] ? (~i_sum + 10'h001) : i_sum;
  assign i_mag = lead_open ? i_abs[9:2] : {1'b0, i_abs[9:3]};
  assign nxt_li = {i_sum[9], 1'b0,
                   (i_mag > 8'h3F) ? `LFC_MAG_MAX : i_mag[5:0]};

  // Refresh counter and derived results
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 16'h0000;
      lv_ff  <= 8'h00;
      li_ff  <= 8'h00;
    end else if (ce) begin
      cnt_ff <= tick ? 16'h0000 : cnt_ff + 16'h0001;
      if (tick) begin
        lv_ff <= nxt_lv;
        li_ff <= nxt_li;
      end
    end
  end

  assign raw = sense;
  assign results[0] = lv_ff;
  assign results[1] = li_ff;

  // Raw sample capture, one entry per register
  genvar gi;
  for (gi = 0; gi < `LFC_RAW_COUNT; gi++) begin : g_cap
    logic [7:0] cap_ff;
    always_ff @(posedge clk) begin
      if (rst) begin
        cap_ff <= 8'h00;
      end else if (ce && tick) begin
        cap_ff <= raw[gi];
      end
    end
    assign results[gi + 2] = cap_ff;
  end

endmodule
`default_nettype wire

// [testbench/lfc_top_asserts.sv]
// Concurrent checks on the linefeed control block ports
`timescale 1ns/10ps
`default_nettype none
`include "lfc_defs.svh"
module lfc_top_asserts
  import lfc_pkg::*;
#(
  parameter int REFRESH_CYCLES = `LFC_REFRESH_CYC
)
(
  // Clock, reset, enable
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic       CE,
  // Serial control port
  input wire logic       SCLK,
  input wire logic       CS_N,
  input wire logic       SDI,
  input wire logic       SDO_O,
  input wire logic       SDO_OE,
  // Samples and alarm
  input wire lfc_sense_t SENSE,
  input wire logic       PWR_ALARM,
  // Driver control and settings
  input wire lfc_drive_t DRIVE,
  input wire lfc_state_t LINE_STATE_SEL,
  input wire logic [2:0] FEED_CURRENT_CAP_SEL,
  input wire logic [5:0] OPEN_LOOP_VOLT_SEL,
  input wire logic [5:0] HEADROOM_OFFSET_SEL,
  input wire logic       INT_N
);
  // One clock domain
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  // Reset leaves the line open with default feed settings
  AST_RESET_VALUES: assert property ($past(RST) |->
    LINE_STATE_SEL == LFC_OPEN && FEED_CURRENT_CAP_SEL == 3'h0 &&
    OPEN_LOOP_VOLT_SEL == 6'h20 && HEADROOM_OFFSET_SEL == 6'h02)
    else $error("reset values wrong");
  // Drive follows the state one clock later
  AST_OPEN_NO_DRIVE: assert property (
    CE && LINE_STATE_SEL == LFC_OPEN |=> DRIVE == 5'h00)
    else $error("open state still drives");
  AST_ACTIVE_FEED: assert property (
    CE && LINE_STATE_SEL inside {LFC_FWD_ACT, LFC_REV_ACT} |=>
    DRIVE.tip_drive && DRIVE.ring_drive && !DRIVE.audio_pwr)
    else $error("active state drive wrong");
  AST_OHT_AUDIO: assert property (
    CE && LINE_STATE_SEL inside {LFC_FWD_OHT, LFC_REV_OHT} |=>
    DRIVE.tip_drive && DRIVE.ring_drive && DRIVE.audio_pwr)
    else $error("on-hook transmission drive wrong");
  AST_TIP_OPEN: assert property (
    CE && LINE_STATE_SEL == LFC_TIP_OPEN |=>
    !DRIVE.tip_drive && DRIVE.ring_drive)
    else $error("tip open drive wrong");
  AST_RING_OPEN: assert property (
    CE && LINE_STATE_SEL == LFC_RING_OPEN |=>
    DRIVE.tip_drive && !DRIVE.ring_drive)
    else $error("ring open drive wrong");
  AST_RINGING: assert property (
    CE && LINE_STATE_SEL == LFC_RINGING |=> DRIVE.ring_gen)
    else $error("ringing generator off");
  AST_DRIVE_STEADY: assert property (
    CE && $past(CE) && $stable(LINE_STATE_SEL) |=> $stable(DRIVE))
    else $error("drive moved without state change");
  // Read data driver lets go once the select is seen high
  AST_OE_RELEASE: assert property (
    $rose(CS_N) |-> ##[1:6] !SDO_OE)
    else $error("read data driver not released");

  // Main scenarios reached
  COV_RINGING: cover property (LINE_STATE_SEL == LFC_RINGING);
  COV_READ: cover property ($rose(SDO_OE));
  COV_IRQ: cover property ($fell(INT_N));
endmodule

bind lfc_top lfc_top_asserts #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (
  .MCLK(MCLK), .RST(RST), .CE(CE), .SCLK(SCLK), .CS_N(CS_N), .SDI(SDI),
  .SDO_O(SDO_O), .SDO_OE(SDO_OE), .SENSE(SENSE), .PWR_ALARM(PWR_ALARM),
  .DRIVE(DRIVE), .LINE_STATE_SEL(LINE_STATE_SEL),
  .FEED_CURRENT_CAP_SEL(FEED_CURRENT_CAP_SEL),
  .OPEN_LOOP_VOLT_SEL(OPEN_LOOP_VOLT_SEL),
  .HEADROOM_OFFSET_SEL(HEADROOM_OFFSET_SEL), .INT_N(INT_N));
`default_nettype wire

// [testbench/lfc_line_model.sv]
// Behavioural model of the external line drivers and sense circuitry
`timescale 1ns/10ps
`default_nettype none
module lfc_line_model
  import lfc_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Wanted readings and fault injection
  input  wire lfc_sense_t sense_set,
  input  wire logic       trip,
  // Enables from the block
  input  wire lfc_drive_t drive,
  // Readings and alarm toward the block
  output var lfc_sense_t  sense,
  output logic            pwr_alarm
);
  logic feeding;

  // Transistors carry current only while a lead is driven
  assign feeding = drive.tip_drive | drive.ring_drive;
  // Overheating can only come from a driven transistor
  assign pwr_alarm = trip & feeding;

  // Converter samples, currents gone with all drive off
  always_ff @(posedge clk) begin
    sense <= feeding ? sense_set : {48'h0, sense_set[31:0]};
  end
endmodule
`default_nettype wire

// [testbench/lfc_top_tb_top.sv]
// Self-checking bench for the linefeed state and feed control block
`timescale 1ns/10ps
`default_nettype none
module lfc_top_tb_top;
  import lfc_pkg::*;
  localparam int RC = 20;
  localparam int HP = 8;
  // One ordinary register case
  typedef struct {
    logic [6:0] adr;
    logic [7:0] dat;
    logic [7:0] exp;
    logic [4:0] drv;
  } lfc_row_t;

  logic       mclk  = 1'b0;
  logic       rst   = 1'b1;
  logic       ce    = 1'b1;
  logic       sclk  = 1'b0;
  logic       cs_n  = 1'b1;
  logic       sdi   = 1'b0;
  logic       trip  = 1'b0;
  lfc_sense_t sense_set = '0;
  lfc_sense_t sense;
  logic       sdo_o, sdo_oe, pwr_alarm, int_n;
  lfc_drive_t drive;
  lfc_state_t line_sel;
  logic [2:0] cur_sel;
  logic [5:0] ocv_sel, cmo_sel;
  logic [7:0] v;
  logic       oe = 1'b0;
  int         fails = 0;
  int         compares = 0;
  // Settings and one unmapped address first, then every state code
  lfc_row_t rows [12] = '{
    '{7'h47, 8'hFF, 8'h07, 5'h00},
    '{7'h48, 8'h3F, 8'h3F, 5'h00},
    '{7'h49, 8'h15, 8'h15, 5'h00},
    '{7'h7F, 8'hA5, 8'h00, 5'h00},
    '{7'h40, 8'h01, 8'h01, 5'h18}, '{7'h40, 8'h02, 8'h02, 5'h1C},
    '{7'h40, 8'h03, 8'h03, 5'h08}, '{7'h40, 8'h04, 8'h04, 5'h1A},
    '{7'h40, 8'h05, 8'h05, 5'h19}, '{7'h40, 8'h06, 8'h06, 5'h1D},
    '{7'h40, 8'h07, 8'h07, 5'h10}, '{7'h40, 8'h00, 8'h00, 5'h00}};
  // Results 0x4E..0x59 for the sample set below
  logic [7:0] meas [12] = '{8'h90, 8'h09, 8'h50, 8'h10, 8'h77, 8'h66,
                            8'h40, 8'h10, 8'h02, 8'h03, 8'h20, 8'h08};

  always #10 mclk = ~mclk;

  lfc_top #(.REFRESH_CYCLES(RC)) uut (
    .MCLK(mclk), .RST(rst), .CE(ce), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi),
    .SDO_O(sdo_o), .SDO_OE(sdo_oe), .SENSE(sense), .PWR_ALARM(pwr_alarm),
    .DRIVE(drive), .LINE_STATE_SEL(line_sel),
    .FEED_CURRENT_CAP_SEL(cur_sel), .OPEN_LOOP_VOLT_SEL(ocv_sel),
    .HEADROOM_OFFSET_SEL(cmo_sel), .INT_N(int_n));
  lfc_line_model u_line (.clk(mclk), .sense_set(sense_set), .trip(trip),
    .drive(drive), .sense(sense), .pwr_alarm(pwr_alarm));

  // Wait on falling clock edges
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One 16-bit serial frame, MSB first, sampled on SCLK rise
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    cs_n = 1'b0;
    tick(HP);
    for (int i = 15; i >= 0; i--) begin
      sdi = tx[i];
      tick(HP);
      sclk = 1'b1;
      if (i < 8) rx[i] = sdo_oe ? sdo_o : ~sdo_o;
      if (i == 0) oe = sdo_oe;
      tick(HP);
      sclk = 1'b0;
    end
    tick(HP);
    cs_n = 1'b1;
    sdi = 1'b0;
    tick(HP);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer({1'b0, a, d}, x);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    xfer({1'b1, a, 8'h00}, d);
  endtask
  // Setting pin that belongs to an address
  function automatic logic [7:0] pin(input logic [6:0] a);
    case (a)
      7'h40: return {5'h0, line_sel};
      7'h47: return {5'h0, cur_sel};
      7'h48: return {2'h0, ocv_sel};
      7'h49: return {2'h0, cmo_sel};
      default: return 8'h00;
    endcase
  endfunction
  task automatic do_reset();
    rst = 1'b1;
    tick(5);
    rst = 1'b0;
    tick(4);
  endtask
  task automatic trip_pulse();
    trip = 1'b1;
    tick(6);
    trip = 1'b0;
    tick(10);
  endtask
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].adr, rows[i].dat);
      check({7'h0, oe}, 8'h00);
      rd(rows[i].adr, v);
      check({7'h0, oe}, 8'h01);
      check({7'h0, sdo_oe}, 8'h00);
      check(v, rows[i].exp);
      check(pin(rows[i].adr), rows[i].exp);
      check({3'h0, drive}, {3'h0, rows[i].drv});
    end
    $display("register table test done");
    // Reset in mid-run returns to open with defaults
    wr(7'h40, 8'h05);
    wr(7'h47, 8'h03);
    do_reset();
    check({5'h0, line_sel}, 8'h00);
    check({5'h0, cur_sel}, 8'h00);
    check({2'h0, ocv_sel}, 8'h20);
    check({2'h0, cmo_sel}, 8'h02);
    check({3'h0, drive}, 8'h00);
    $display("reset test done");
    // Power alarm with and without automatic open
    wr(7'h42, 8'h01);
    wr(7'h40, 8'h01);
    trip_pulse();
    check({5'h0, line_sel}, 8'h00);
    check({3'h0, drive}, 8'h00);
    rd(7'h13, v);
    check(v, 8'h01);
    check({7'h0, int_n}, 8'h01);
    wr(7'h42, 8'h02);
    check({7'h0, int_n}, 8'h00);
    wr(7'h13, 8'h01);
    check({7'h0, int_n}, 8'h01);
    wr(7'h40, 8'h05);
    trip_pulse();
    check({5'h0, line_sel}, 8'h05);
    check({7'h0, int_n}, 8'h00);
    $display("alarm test done");
    // Measurement results and derived loop values
    sense_set = 80'h08_20_03_02_10_40_66_77_10_50;
    wr(7'h40, 8'h01);
    tick(2 * RC);
    foreach (meas[i]) begin
      rd(7'h4E + 7'(i), v);
      check(v, meas[i]);
    end
    wr(7'h40, 8'h03);
    tick(2 * RC);
    rd(7'h4E, v);
    check(v, 8'h84);
    rd(7'h4F, v);
    check(v, 8'h12);
    sense_set[7:0] = 8'h54;
    wr(7'h40, 8'h07);
    tick(2 * RC);
    rd(7'h4F, v);
    check(v, 8'h12);
    rd(7'h50, v);
    check(v, 8'h54);
    $display("measurement test done");
    // Frozen clock enable ignores a whole frame
    ce = 1'b0;
    wr(7'h40, 8'h01);
    ce = 1'b1;
    tick(2);
    check({5'h0, line_sel}, 8'h07);
    $display("clock enable test done");
    stop_test();
  end
endmodule
`default_nettype wire
